// File: psd_map.vh
/*
  psd_map.vh: register byte offsets, field positions and reset values of the
  pulse-width generator with dead-band and output stage.
  Assumes a byte address port and 32-bit word registers on aligned offsets.
*/
`ifndef PSD_MAP_VH
`define PSD_MAP_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PSD_REG_UPD_CTL 8'h00
`define PSD_REG_CNT_SYNC 8'h04
`define PSD_REG_PIN_GATE 8'h08
`define PSD_REG_PIN_FLIP 8'h0c
`define PSD_REG_FAULT_EN 8'h10
`define PSD_REG_MOD_INTEN 8'h14
`define PSD_REG_MOD_RIS 8'h18
`define PSD_REG_MOD_ISC 8'h1c
`define PSD_REG_MOD_STAT 8'h20
`define PSD_REG_GEN_CTL 8'h40
`define PSD_REG_GEN_INTEN 8'h44
`define PSD_REG_GEN_RIS 8'h48
`define PSD_REG_GEN_ISC 8'h4c
`define PSD_REG_PERIOD 8'h50
`define PSD_REG_COUNT 8'h54
`define PSD_REG_CMP_A 8'h58
`define PSD_REG_CMP_B 8'h5c
`define PSD_REG_ACT_A 8'h60
`define PSD_REG_ACT_B 8'h64
`define PSD_REG_DB_CTL 8'h68
`define PSD_REG_DB_RISE 8'h6c
`define PSD_REG_DB_FALL 8'h70
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSD_GC_RUN 0
`define PSD_GC_UPDOWN 1
`define PSD_GC_SYNCUPD 2
`define PSD_GC_DBGRUN 3
`define PSD_MI_GEN 0
`define PSD_MI_FAULT 1
`define PSD_GI_TRIG_LSB 8
`define PSD_DB_EN 0
`define PSD_EV_ZERO 0
`define PSD_EV_LOAD 1
`define PSD_EV_AUP 2
`define PSD_EV_ADN 3
`define PSD_EV_BUP 4
`define PSD_EV_BDN 5
// ----------------------------------------------------------------
// action codes and reset values
// ----------------------------------------------------------------
`define PSD_ACT_KEEP 2'h0
`define PSD_ACT_TOGGLE 2'h1
`define PSD_ACT_LOW 2'h2
`define PSD_ACT_HIGH 2'h3
`define PSD_RST_WORD 32'h0000_0000
`define PSD_RST_CNT 16'h0000
`define PSD_RST_DB 12'h000
`endif

// File: psd_top.v
/*
  psd_top.v: one pulse-width generator with counter, two comparators, per-event
  output actions, dead-band pair, interrupt and converter trigger selection,
  fault and debug stall handling, and the pin gating and polarity stage.
  Assumes a single-cycle register master on CLK_SYS; FAULT_IN and DBG_STALL
  come from outside the clock domain and are synchronised here.
*/
`timescale 1ns/1ps
`include "psd_map.vh"
`default_nettype none

module psd_top (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire FAULT_IN,
  input wire DBG_STALL,
  output reg PWM_OUT0,
  output reg PWM_OUT1,
  output reg INT_OUT,
  output reg ADC_TRIG
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // action decode
  function act;
    input cur;
    input [1:0] code;
    begin
      case (code)
        `PSD_ACT_TOGGLE: act = ~cur;
        `PSD_ACT_LOW: act = 1'b0;
        `PSD_ACT_HIGH: act = 1'b1;
        default: act = cur;
      endcase
    end
  endfunction
  // zero then load, then one compare event; own comparator preferred
  function gen_step;
    input cur;
    input [11:0] code;
    input [5:0] ev;
    input own_b;
    reg x;
    begin
      x = cur;
      if (ev[`PSD_EV_ZERO])
        x = act(x, code[2*`PSD_EV_ZERO +: 2]);
      if (ev[`PSD_EV_LOAD])
        x = act(x, code[2*`PSD_EV_LOAD +: 2]);
      if (!own_b && (ev[`PSD_EV_AUP] || ev[`PSD_EV_ADN])) begin
        x = ev[`PSD_EV_AUP] ? act(x, code[2*`PSD_EV_AUP +: 2]) : act(x, code[2*`PSD_EV_ADN +: 2]);
      end else if (ev[`PSD_EV_BUP] || ev[`PSD_EV_BDN]) begin
        x = ev[`PSD_EV_BUP] ? act(x, code[2*`PSD_EV_BUP +: 2]) : act(x, code[2*`PSD_EV_BDN +: 2]);
      end else if (ev[`PSD_EV_AUP] || ev[`PSD_EV_ADN]) begin
        x = ev[`PSD_EV_AUP] ? act(x, code[2*`PSD_EV_AUP +: 2]) : act(x, code[2*`PSD_EV_ADN +: 2]);
      end
      gen_step = x;
    end
  endfunction
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg upd_req_r;
  reg sync_req_r;
  reg [1:0] gate_r;
  reg [1:0] flip_r;
  reg [1:0] fault_en_r;
  reg [1:0] mod_inten_r;
  reg fault_sticky_r;
  reg [3:0] gen_ctl_r;
  reg [5:0] int_sel_r;
  reg [5:0] trig_sel_r;
  reg [5:0] gen_ris_r;
  reg [15:0] load_sh_r;
  reg [15:0] cmpa_sh_r;
  reg [15:0] cmpb_sh_r;
  reg [15:0] load_r;
  reg [15:0] cmpa_r;
  reg [15:0] cmpb_r;
  reg [11:0] act_a_r;
  reg [11:0] act_b_r;
  reg db_en_r;
  reg [11:0] db_rise_r;
  reg [11:0] db_fall_r;
  reg [15:0] cnt_r;
  reg dir_r;
  reg halt_r;
  reg gen_a_r;
  reg gen_b_r;
  reg [11:0] rcnt_r;
  reg [11:0] fcnt_r;
  reg fault_m_r;
  reg fault_s_r;
  reg stall_m_r;
  reg stall_s_r;
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fault_m_r <= 1'b0;
      fault_s_r <= 1'b0;
      stall_m_r <= 1'b0;
      stall_s_r <= 1'b0;
    end else begin
      fault_m_r <= FAULT_IN;
      fault_s_r <= fault_m_r;
      stall_m_r <= DBG_STALL;
      stall_s_r <= stall_m_r;
    end
  end
  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  wire run = gen_ctl_r[`PSD_GC_RUN];
  wire ud = gen_ctl_r[`PSD_GC_UPDOWN];
  wire at_zero = (cnt_r == `PSD_RST_CNT);
  wire at_load = (cnt_r == load_r);
  // stop at zero unless told to keep running
  wire hold = stall_s_r && !gen_ctl_r[`PSD_GC_DBGRUN] && at_zero;
  wire ev_ok = run && !halt_r;
  wire ev_zero = ev_ok && at_zero;
  wire ev_load = ev_ok && at_load;
  // compare suppressed at zero and load
  wire ma = ev_ok && (cnt_r == cmpa_r) && (cmpa_r <= load_r) && !at_zero && !at_load;
  wire mb = ev_ok && (cnt_r == cmpb_r) && (cmpb_r <= load_r) && !at_zero && !at_load;
  // down mode keeps dir low, only down matches
  wire [5:0] ev = {mb && !dir_r, mb && dir_r, ma && !dir_r, ma && dir_r,
                   ev_load, ev_zero};
  // ----------------------------------------------------------------
  // update of active values
  // ----------------------------------------------------------------
  // immediate mode copies at zero
  wire upd_now = at_zero && !halt_r &&
                 (!gen_ctl_r[`PSD_GC_SYNCUPD] || upd_req_r);
  wire [15:0] load_use = upd_now ? load_sh_r : load_r;
  wire upd_wr = WR && (ADDR == `PSD_REG_UPD_CTL) && WDATA[0];
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      load_r <= `PSD_RST_CNT;
      cmpa_r <= `PSD_RST_CNT;
      cmpb_r <= `PSD_RST_CNT;
      upd_req_r <= 1'b0;
    end else begin
      if (upd_now) begin
        load_r <= load_sh_r;
        cmpa_r <= cmpa_sh_r;
        cmpb_r <= cmpb_sh_r;
      end
      // a new request arriving as one completes stays pending
      if (upd_wr)
        upd_req_r <= 1'b1;
      else if (upd_now && gen_ctl_r[`PSD_GC_SYNCUPD])
        upd_req_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt_r <= `PSD_RST_CNT;
      dir_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      halt_r <= run && hold;
      if (sync_req_r) begin
        cnt_r <= `PSD_RST_CNT;
        dir_r <= 1'b0;
      end else if (run && !hold) begin
        // reload at zero gives load plus one clocks
        if (!ud) begin
          dir_r <= 1'b0;
          cnt_r <= at_zero ? load_use : cnt_r - 16'h0001;
        end else if (at_zero) begin
          dir_r <= (load_use != `PSD_RST_CNT);
          cnt_r <= (load_use != `PSD_RST_CNT) ? 16'h0001 : `PSD_RST_CNT;
        end else if (at_load || !dir_r) begin
          dir_r <= 1'b0;
          cnt_r <= cnt_r - 16'h0001;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // signal generator and dead-band
  // ----------------------------------------------------------------
  wire gen_a_nxt = gen_step(gen_a_r, act_a_r, ev, 1'b0);
  wire gen_b_nxt = gen_step(gen_b_r, act_b_r, ev, 1'b1);
  // rise waits for the rise count
  wire db_a = gen_a_r && (rcnt_r == db_rise_r);
  // inverse, rise waits for the fall count
  wire db_b = !gen_a_r && (fcnt_r == db_fall_r);
  wire sig0 = db_en_r ? db_a : gen_a_r;
  wire sig1 = db_en_r ? db_b : gen_b_r;
  wire flt = fault_s_r;
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      gen_a_r <= 1'b0;
      gen_b_r <= 1'b0;
      rcnt_r <= `PSD_RST_DB;
      fcnt_r <= `PSD_RST_DB;
    end else begin
      gen_a_r <= gen_a_nxt;
      gen_b_r <= gen_b_nxt;
      // delay counters restart on every edge of the source
      if (!gen_a_r)
        rcnt_r <= `PSD_RST_DB;
      else if (rcnt_r != db_rise_r)
        rcnt_r <= rcnt_r + 12'h001;
      if (gen_a_r)
        fcnt_r <= `PSD_RST_DB;
      else if (fcnt_r != db_fall_r)
        fcnt_r <= fcnt_r + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // output stage, interrupt and trigger
  // ----------------------------------------------------------------
  wire [5:0] int_hit = ev & int_sel_r;
  wire [1:0] mod_ris = {fault_sticky_r, |gen_ris_r};
  wire [1:0] mod_isc = mod_ris & mod_inten_r;

  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PWM_OUT0 <= 1'b0;
      PWM_OUT1 <= 1'b0;
      INT_OUT <= 1'b0;
      ADC_TRIG <= 1'b0;
    end else begin
      PWM_OUT0 <= (sig0 && gate_r[0] && !(flt && fault_en_r[0])) ^ flip_r[0];
      PWM_OUT1 <= (sig1 && gate_r[1] && !(flt && fault_en_r[1])) ^ flip_r[1];
      INT_OUT <= |mod_isc;
      ADC_TRIG <= |(ev & trig_sel_r);
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync_req_r <= 1'b0;
      gate_r <= 2'h0;
      flip_r <= 2'h0;
      fault_en_r <= 2'h0;
      mod_inten_r <= 2'h0;
      fault_sticky_r <= 1'b0;
      gen_ctl_r <= 4'h0;
      int_sel_r <= 6'h00;
      trig_sel_r <= 6'h00;
      gen_ris_r <= 6'h00;
      load_sh_r <= `PSD_RST_CNT;
      cmpa_sh_r <= `PSD_RST_CNT;
      cmpb_sh_r <= `PSD_RST_CNT;
      act_a_r <= 12'h000;
      act_b_r <= 12'h000;
      db_en_r <= 1'b0;
      db_rise_r <= `PSD_RST_DB;
      db_fall_r <= `PSD_RST_DB;
    end else begin
      sync_req_r <= WR && (ADDR == `PSD_REG_CNT_SYNC) && WDATA[0];
      // set wins over the write-one clear
      if (flt)
        fault_sticky_r <= 1'b1;
      else if (WR && (ADDR == `PSD_REG_MOD_ISC) && WDATA[`PSD_MI_FAULT])
        fault_sticky_r <= 1'b0;
      if (WR && (ADDR == `PSD_REG_GEN_ISC))
        gen_ris_r <= (gen_ris_r & ~WDATA[5:0]) | int_hit;
      else
        gen_ris_r <= gen_ris_r | int_hit;
      if (WR) begin
        case (ADDR)
          `PSD_REG_PIN_GATE: gate_r <= WDATA[1:0];
          `PSD_REG_PIN_FLIP: flip_r <= WDATA[1:0];
          `PSD_REG_FAULT_EN: fault_en_r <= WDATA[1:0];
          `PSD_REG_MOD_INTEN: mod_inten_r <= WDATA[1:0];
          `PSD_REG_GEN_CTL: gen_ctl_r <= WDATA[3:0];
          `PSD_REG_GEN_INTEN: begin
            int_sel_r <= WDATA[5:0];
            trig_sel_r <= WDATA[`PSD_GI_TRIG_LSB+5:`PSD_GI_TRIG_LSB];
          end
          `PSD_REG_PERIOD: load_sh_r <= WDATA[15:0];
          `PSD_REG_CMP_A: cmpa_sh_r <= WDATA[15:0];
          `PSD_REG_CMP_B: cmpb_sh_r <= WDATA[15:0];
          `PSD_REG_ACT_A: act_a_r <= WDATA[11:0];
          `PSD_REG_ACT_B: act_b_r <= WDATA[11:0];
          `PSD_REG_DB_CTL: db_en_r <= WDATA[`PSD_DB_EN];
          `PSD_REG_DB_RISE: db_rise_r <= WDATA[11:0];
          `PSD_REG_DB_FALL: db_fall_r <= WDATA[11:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read data stand one cycle only; unmapped offsets read zero
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= `PSD_RST_WORD;
    end else if (!RD) begin
      RDATA <= `PSD_RST_WORD;
    end else begin
      case (ADDR)
        `PSD_REG_UPD_CTL: RDATA <= {31'h0, upd_req_r};
        `PSD_REG_CNT_SYNC: RDATA <= {31'h0, sync_req_r};
        `PSD_REG_PIN_GATE: RDATA <= {30'h0, gate_r};
        `PSD_REG_PIN_FLIP: RDATA <= {30'h0, flip_r};
        `PSD_REG_FAULT_EN: RDATA <= {30'h0, fault_en_r};
        `PSD_REG_MOD_INTEN: RDATA <= {30'h0, mod_inten_r};
        `PSD_REG_MOD_RIS: RDATA <= {30'h0, mod_ris};
        `PSD_REG_MOD_ISC: RDATA <= {30'h0, mod_isc};
        `PSD_REG_MOD_STAT: RDATA <= {31'h0, flt};
        `PSD_REG_GEN_CTL: RDATA <= {28'h0, gen_ctl_r};
        `PSD_REG_GEN_INTEN: RDATA <= {18'h0, trig_sel_r, 2'h0, int_sel_r};
        `PSD_REG_GEN_RIS: RDATA <= {26'h0, gen_ris_r};
        `PSD_REG_GEN_ISC: RDATA <= {26'h0, gen_ris_r};
        `PSD_REG_PERIOD: RDATA <= {16'h0, load_sh_r};
        `PSD_REG_COUNT: RDATA <= {16'h0, cnt_r};
        `PSD_REG_CMP_A: RDATA <= {16'h0, cmpa_sh_r};
        `PSD_REG_CMP_B: RDATA <= {16'h0, cmpb_sh_r};
        `PSD_REG_ACT_A: RDATA <= {20'h0, act_a_r};
        `PSD_REG_ACT_B: RDATA <= {20'h0, act_b_r};
        `PSD_REG_DB_CTL: RDATA <= {31'h0, db_en_r};
        `PSD_REG_DB_RISE: RDATA <= {20'h0, db_rise_r};
        `PSD_REG_DB_FALL: RDATA <= {20'h0, db_fall_r};
        default: RDATA <= `PSD_RST_WORD;
      endcase
    end
  end

endmodule // psd_top

`default_nettype wire

// File: psd_top_sva.sv
/*
  psd_top_sva.sv: port-level checker for the pulse-width block.
  Assumes it is bound to psd_top and snoops register writes on its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psd_map.vh"
module psd_top_sva (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic FAULT_IN,
  input wire logic DBG_STALL,
  input wire logic PWM_OUT0,
  input wire logic PWM_OUT1,
  input wire logic INT_OUT,
  input wire logic ADC_TRIG
);
  // ------------
  // register snoop
  // ------------
  // q_r counts quiet cycles since a write, so checks skip register latency
  logic [2:0] q_r;
  logic [2:0] f_r;
  logic [1:0] gate_r, flip_r, fen_r, mien_r;
  logic [5:0] trig_r;
  logic db_r;
  logic [15:0] per_r;
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      {q_r, f_r, gate_r, flip_r, fen_r, mien_r, trig_r, db_r, per_r} <= '0;
    end else begin
      q_r <= WR ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
      f_r <= !FAULT_IN ? 3'h0 : f_r + {2'h0, f_r != 3'h7};
      if (WR) begin
        case (ADDR)
          `PSD_REG_PIN_GATE: gate_r <= WDATA[1:0];
          `PSD_REG_PIN_FLIP: flip_r <= WDATA[1:0];
          `PSD_REG_FAULT_EN: fen_r <= WDATA[1:0];
          `PSD_REG_MOD_INTEN: mien_r <= WDATA[1:0];
          `PSD_REG_GEN_INTEN: trig_r <= WDATA[13:8];
          `PSD_REG_DB_CTL: db_r <= WDATA[0];
          `PSD_REG_PERIOD: per_r <= WDATA[15:0];
          default: ;
        endcase
      end
    end
  end
  // ------------
  // properties
  // ------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  chk_reset_low: assert property (
    $fell(SYS_RST) |-> !PWM_OUT0 && !PWM_OUT1 && !INT_OUT)
    else $error("outputs not low after reset");
  chk_gate_zero: assert property (
    q_r >= 3'h3 |-> (gate_r[0] || PWM_OUT0 == flip_r[0]) && (gate_r[1] || PWM_OUT1 == flip_r[1]))
    else $error("gated pin not at idle level");
  chk_fault_force: assert property (
    f_r >= 3'h5 && q_r >= 3'h3 |->
      (!fen_r[0] || PWM_OUT0 == flip_r[0]) && (!fen_r[1] || PWM_OUT1 == flip_r[1]))
    else $error("fault did not force pin inactive");
  chk_fault_int: assert property (
    mien_r[1] && f_r == 3'h4 |-> ##[0:4] INT_OUT)
    else $error("fault interrupt missing");
  chk_int_masked: assert property (
    q_r >= 3'h3 && mien_r == 2'h0 |-> !INT_OUT)
    else $error("interrupt with all sources masked");
  chk_trig_none: assert property (
    q_r >= 3'h3 && trig_r == 6'h00 |-> !ADC_TRIG)
    else $error("trigger with no event selected");
  chk_db_pair: assert property (
    db_r && flip_r == 2'h0 && q_r == 3'h7 |-> !(PWM_OUT0 && PWM_OUT1))
    else $error("both dead-band outputs high");
  chk_period_rd: assert property (
    RD && ADDR == `PSD_REG_PERIOD |=> RDATA == {16'h0000, per_r})
    else $error("period readback wrong");
  cov_fault_int: cover property (FAULT_IN && INT_OUT);
  cov_trig: cover property (ADC_TRIG ##1 !ADC_TRIG);
  cov_stall: cover property (DBG_STALL ##1 DBG_STALL);
  cov_db: cover property (db_r && PWM_OUT1);
endmodule // psd_top_sva
`default_nettype wire

// File: psd_bridge_model.sv
/*
  psd_bridge_model.sv: half-bridge driver model on the two pins.
  Assumes pin 0 drives the high side and pin 1 the low side; it measures
  widths and reports a fault only when the bench commands a trip.
*/
`timescale 1ns/1ps
`default_nettype none
module psd_bridge_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic hi_in,
  input wire logic lo_in,
  input wire logic trip,
  output logic fault_out,
  output logic [7:0] per0,
  output logic [7:0] hi0,
  output logic [7:0] hi1,
  output logic [7:0] shoot,
  output logic [7:0] edges
);
  logic hq, lq;
  logic [7:0] c0, w0, w1;
  // a real driver reports overcurrent as a level
  assign fault_out = trip;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {hq, lq, c0, w0, w1, per0, hi0, hi1, shoot, edges} <= '0;
    end else begin
      hq <= hi_in;
      lq <= lo_in;
      c0 <= (hi_in && !hq) ? 8'h01 : c0 + 8'h01;
      if (hi_in && !hq) per0 <= c0;
      w0 <= hi_in ? w0 + 8'h01 : 8'h00;
      if (!hi_in && hq) hi0 <= w0;
      w1 <= lo_in ? w1 + 8'h01 : 8'h00;
      if (!lo_in && lq) hi1 <= w1;
      // both switches on means shoot-through current
      if (hi_in && lo_in) shoot <= shoot + 8'h01;
      if (hi_in != hq || lo_in != lq) edges <= edges + 8'h01;
    end
  end
endmodule // psd_bridge_model
`default_nettype wire

// File: tb_top.sv
/*
  tb_top.sv: self-checking bench for psd_top with the bridge model.
  Assumes psd_top, psd_bridge_model and psd_top_sva are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psd_map.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall = 1'b0;
  logic trip = 1'b0;
  wire [31:0] rdata;
  wire fault, pin0, pin1, irq, trig;
  wire [7:0] per0, hi0, hi1, shoot, edges;
  int failures = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] a, b;
  logic [7:0] offs [6] = '{`PSD_REG_GEN_CTL, `PSD_REG_PERIOD, `PSD_REG_COUNT,
    `PSD_REG_ACT_A, `PSD_REG_DB_RISE, 8'h7c};
  always #5 clk = ~clk;
  psd_top i_psd_top (
    .CLK_SYS(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .FAULT_IN(fault), .DBG_STALL(stall), .PWM_OUT0(pin0),
    .PWM_OUT1(pin1), .INT_OUT(irq), .ADC_TRIG(trig));
  psd_bridge_model i_psd_bridge_model (
    .clk(clk), .rst(rst), .hi_in(pin0), .lo_in(pin1), .trip(trip), .fault_out(fault),
    .per0(per0), .hi0(hi0), .hi1(hi1), .shoot(shoot), .edges(edges));
  // ------------
  // access tasks
  // ------------
  task automatic wr_reg(input logic [7:0] a_i, input logic [31:0] d_i);
    @(posedge clk);
    addr <= a_i;
    wdata <= d_i;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a_i, output logic [31:0] d_o);
    @(posedge clk);
    addr <= a_i;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d_o = rdata;
  endtask
  task automatic chk_reg(input logic [7:0] a_i, input logic [31:0] e_i);
    logic [31:0] d;
    rd_reg(a_i, d);
    `CHK("register", e_i, d)
  endtask
  // settle one ns past the edge so registered outputs have landed
  task automatic ticks(input int n_i);
    repeat (n_i) @(posedge clk);
    #1;
  endtask
  task automatic tally(input logic sel, output int c);
    c = 0;
    repeat (32) begin
      @(posedge clk);
      #1 c = c + (sel ? pin1 : trig);
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------
  // tests
  // ------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) chk_reg(offs[i], 32'h0);
    endt("reset");
    wr_reg(`PSD_REG_PERIOD, 32'h3);
    wr_reg(`PSD_REG_CMP_A, 32'h1);
    wr_reg(`PSD_REG_ACT_A, 32'h83);
    wr_reg(`PSD_REG_ACT_B, 32'h4);
    wr_reg(`PSD_REG_PIN_GATE, 32'h3);
    ticks(10);
    chk_reg(`PSD_REG_COUNT, 32'h0);
    wr_reg(`PSD_REG_GEN_CTL, 32'h1);
    ticks(40);
    `CHK("period0", 8'h04, per0)
    `CHK("high0", 8'h03, hi0)
    `CHK("high1", 8'h04, hi1)
    endt("down count");
    // a match equal to load, and one beyond it, must both stay silent
    wr_reg(`PSD_REG_CMP_A, 32'h3);
    wr_reg(`PSD_REG_CMP_B, 32'h9);
    wr_reg(`PSD_REG_ACT_A, 32'h40);
    wr_reg(`PSD_REG_ACT_B, 32'h400);
    ticks(12);
    n = edges;
    ticks(24);
    `CHK("edges", n[7:0], edges)
    endt("ignored matches");
    wr_reg(`PSD_REG_PERIOD, 32'h4);
    wr_reg(`PSD_REG_CMP_A, 32'h2);
    wr_reg(`PSD_REG_CMP_B, 32'h2);
    wr_reg(`PSD_REG_ACT_A, 32'h1b0);
    wr_reg(`PSD_REG_ACT_B, 32'he10);
    wr_reg(`PSD_REG_GEN_CTL, 32'h3);
    ticks(50);
    `CHK("period0", 8'h08, per0)
    `CHK("high0", 8'h04, hi0)
    `CHK("high1", 8'h04, hi1)
    endt("up down");
    wr_reg(`PSD_REG_DB_RISE, 32'h2);
    wr_reg(`PSD_REG_DB_FALL, 32'h3);
    wr_reg(`PSD_REG_DB_CTL, 32'h1);
    ticks(20);
    n = shoot;
    ticks(40);
    `CHK("high0", 8'h02, hi0)
    `CHK("high1", 8'h01, hi1)
    `CHK("overlap", n[7:0], shoot)
    endt("dead band");
    for (int e = 0; e < 6; e++) begin
      wr_reg(`PSD_REG_GEN_INTEN, 32'h100 << e);
      ticks(4);
      tally(1'b0, n);
      `CHK("triggers", 32'h4, n)
    end
    wr_reg(`PSD_REG_DB_CTL, 32'h0);
    wr_reg(`PSD_REG_GEN_INTEN, 32'h1);
    wr_reg(`PSD_REG_MOD_INTEN, 32'h1);
    ticks(12);
    `CHK("irq", 1'b1, irq)
    chk_reg(`PSD_REG_GEN_RIS, 32'h1);
    wr_reg(`PSD_REG_MOD_INTEN, 32'h0);
    ticks(3);
    `CHK("irq", 1'b0, irq)
    wr_reg(`PSD_REG_GEN_INTEN, 32'h0);
    wr_reg(`PSD_REG_GEN_ISC, 32'h3f);
    chk_reg(`PSD_REG_GEN_RIS, 32'h0);
    endt("events");
    wr_reg(`PSD_REG_PIN_FLIP, 32'h1);
    wr_reg(`PSD_REG_FAULT_EN, 32'h1);
    wr_reg(`PSD_REG_MOD_INTEN, 32'h2);
    trip <= 1'b1;
    ticks(8);
    `CHK("pin0", 1'b1, pin0)
    // a forced pin must hold its idle level through a whole period
    repeat (8) begin
      ticks(1);
      `CHK("pin0", 1'b1, pin0)
    end
    `CHK("irq", 1'b1, irq)
    chk_reg(`PSD_REG_MOD_STAT, 32'h1);
    @(posedge clk) trip <= 1'b0;
    ticks(5);
    wr_reg(`PSD_REG_MOD_ISC, 32'h2);
    ticks(3);
    `CHK("irq", 1'b0, irq)
    wr_reg(`PSD_REG_PIN_GATE, 32'h1);
    ticks(3);
    tally(1'b1, n);
    `CHK("gated", 32'h0, n)
    endt("fault and gate");
    wr_reg(`PSD_REG_PIN_FLIP, 32'h0);
    wr_reg(`PSD_REG_MOD_INTEN, 32'h3);
    wr_reg(`PSD_REG_GEN_CTL, 32'h9);
    stall <= 1'b1;
    ticks(10);
    rd_reg(`PSD_REG_COUNT, a);
    rd_reg(`PSD_REG_COUNT, b);
    `CHK("moving", 1'b1, a !== b)
    wr_reg(`PSD_REG_GEN_CTL, 32'h1);
    ticks(20);
    chk_reg(`PSD_REG_COUNT, 32'h0);
    chk_reg(`PSD_REG_COUNT, 32'h0);
    `CHK("irq", 1'b0, irq)
    @(posedge clk) stall <= 1'b0;
    endt("stall");
    wr_reg(`PSD_REG_PIN_GATE, 32'h3);
    wr_reg(`PSD_REG_GEN_CTL, 32'h7);
    ticks(30);
    wr_reg(`PSD_REG_PERIOD, 32'h3);
    ticks(40);
    `CHK("period0", 8'h08, per0)
    wr_reg(`PSD_REG_UPD_CTL, 32'h1);
    ticks(40);
    `CHK("period0", 8'h06, per0)
    chk_reg(`PSD_REG_UPD_CTL, 32'h0);
    wr_reg(`PSD_REG_GEN_CTL, 32'h0);
    wr_reg(`PSD_REG_CNT_SYNC, 32'h1);
    ticks(3);
    chk_reg(`PSD_REG_COUNT, 32'h0);
    endt("updates");
    results;
  end
  // the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results;
  end
endmodule // tb_top
bind psd_top psd_top_sva i_psd_top_sva (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .FAULT_IN(FAULT_IN), .DBG_STALL(DBG_STALL), .PWM_OUT0(PWM_OUT0),
  .PWM_OUT1(PWM_OUT1), .INT_OUT(INT_OUT), .ADC_TRIG(ADC_TRIG));
`default_nettype wire
